// ---- bench/sfa_nv_asserts.sv ----
// concurrent checks on the ports of the nonvolatile access block
`timescale 1ns/10ps
module sfa_nv_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic por,
   input wire logic locked,
   input wire sfa_pkg::sfa_req_s cpu_req,
   input wire sfa_pkg::sfa_req_s prg_req,
   input wire sfa_pkg::sfa_rsp_s cpu_rsp,
   input wire sfa_pkg::sfa_rsp_s prg_rsp,
   input wire sfa_pkg::sfa_targets_s targets,
   input wire logic startup_done
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // requests taken at this edge, split by area
   wire logic cpu_take = cpu_req.valid && startup_done;
   wire logic prg_take = prg_req.valid && startup_done;
   wire logic p_user = prg_take && prg_req.area == sfa_pkg::SFA_AREA_USER;
   wire logic p_sig = prg_take && prg_req.area == sfa_pkg::SFA_AREA_SIG;
   wire logic c_sig = cpu_take && cpu_req.area == sfa_pkg::SFA_AREA_SIG && !cpu_req.write;
   // ***********************************
   // answers of both ports
   // ***********************************
   a_cpu_ack_latency: assert property (cpu_take |=> cpu_rsp.ack)
      else $error("cpu answer missing");
   a_prg_ack_cause: assert property (prg_rsp.ack |-> $past(prg_take))
      else $error("programming port answer without request");
   a_cpu_rdata_idle: assert property (!cpu_rsp.ack |-> cpu_rsp.rdata == 8'h00 && !cpu_rsp.refused)
      else $error("cpu answer fields outside ack");
   a_fuse_cpu_refuse: assert property (cpu_take && cpu_req.write &&
      cpu_req.area == sfa_pkg::SFA_AREA_FUSE |=> cpu_rsp.ack && cpu_rsp.refused)
      else $error("cpu fuse write not refused");
   a_sig_write_refuse: assert property (p_sig && prg_req.write |=> prg_rsp.refused)
      else $error("info row write not refused");
   a_user_read_locked: assert property (p_user && !prg_req.write && locked
      |=> prg_rsp.refused && prg_rsp.rdata == 8'h00)
      else $error("locked user read not refused");
   a_user_write_taken: assert property (p_user && prg_req.write |=> !prg_rsp.refused)
      else $error("user write refused");
   a_id_when_locked: assert property (p_sig && !prg_req.write && prg_req.addr <= 5'h02
      |=> prg_rsp.ack && !prg_rsp.refused)
      else $error("identifier read refused");
   a_reserved_zero: assert property (c_sig && (cpu_req.addr == 5'h03 ||
      cpu_req.addr[4:3] == 2'b01) |=> cpu_rsp.ack && cpu_rsp.rdata == 8'h00)
      else $error("reserved info byte not zero");
   a_targets_hold: assert property (startup_done && $past(startup_done) |-> $stable(targets))
      else $error("targets moved without reset");
   cover property (p_user && locked);
   cover property (prg_take && prg_req.write && prg_req.area == sfa_pkg::SFA_AREA_FUSE);
   cover property (cpu_take && cpu_req.write && cpu_req.area == sfa_pkg::SFA_AREA_USER);
endmodule

// ---- bench/sfa_prog_model.sv ----
// behavioural master for one access port of the nonvolatile block
`timescale 1ns/10ps
`include "sfa_map.svh"
module sfa_prog_model (
   input wire logic clock,
   output sfa_pkg::sfa_req_s req,
   input wire sfa_pkg::sfa_rsp_s rsp
);
   // idle until the first transfer
   initial begin
      req = '0;
   end
   // ***********************************
   // one transfer, answer sampled 1 ns after the taking edge
   // ***********************************
   task automatic xfer(input logic wr, input sfa_pkg::sfa_area_e ar, input logic [4:0] a,
      input logic [7:0] wd, output logic [7:0] rd, output logic rf, output logic ak);
      sfa_pkg::sfa_req_s r;
      r = '{1'b1, wr, ar, a, wd};
      // reserved oscillator fuse bits always sent as zero
      if (wr && ar == sfa_pkg::SFA_AREA_FUSE && a == `SFA_FUSE_OSC) r.wdata = wd & 8'h0F;
      @(posedge clock);
      req <= r;
      @(posedge clock);
      // released fields flip so stale values are never reused
      req <= '{1'b0, 1'b0, sfa_pkg::SFA_AREA_NONE, ~a, ~r.wdata};
      #1;
      ak = rsp.ack;
      rf = rsp.refused;
      rd = rsp.rdata;
   endtask
endmodule

// ---- bench/test_sfa_nv_access.sv ----
// self-checking bench of the nonvolatile access block
`timescale 1ns/10ps
`include "sfa_map.svh"
module test_sfa_nv_access;
   // arbitrary identity, calibration and serial values
   localparam logic [23:0] ID_VAL = 24'h3C_C3_07;
   localparam logic [15:0] GAIN_VAL = 16'hB27D;
   localparam logic [15:0] OFS_VAL = 16'hF18A;
   localparam logic [127:0] SER_VAL = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
   localparam sfa_pkg::sfa_area_e AR_SIG = sfa_pkg::SFA_AREA_SIG;
   localparam sfa_pkg::sfa_area_e AR_USER = sfa_pkg::SFA_AREA_USER;
   localparam sfa_pkg::sfa_area_e AR_FUSE = sfa_pkg::SFA_AREA_FUSE;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic por = 1'b1;
   logic locked = 1'b0;
   sfa_pkg::sfa_req_s cpu_req;
   sfa_pkg::sfa_req_s prg_req;
   sfa_pkg::sfa_rsp_s cpu_rsp;
   sfa_pkg::sfa_rsp_s prg_rsp;
   sfa_pkg::sfa_targets_s targets;
   logic startup_done;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [7:0] fz [0:8];
   logic [7:0] ub [0:31];
   logic [55:0] tg;
   logic [7:0] v;
   sfa_nv_access #(.PART_ID(ID_VAL), .GAIN_CAL(GAIN_VAL), .OFFSET_CAL(OFS_VAL),
      .SERIAL(SER_VAL)) sfa_nv_access_inst (.clock(clock), .rst(rst), .por(por),
      .locked(locked), .cpu_req(cpu_req), .prg_req(prg_req), .cpu_rsp(cpu_rsp),
      .prg_rsp(prg_rsp), .targets(targets), .startup_done(startup_done));
   sfa_prog_model sfa_prog_model_inst (.clock(clock), .req(prg_req), .rsp(prg_rsp));
   sfa_prog_model cpu_drv (.clock(clock), .req(cpu_req), .rsp(cpu_rsp));
   // 100 ns clock
   initial begin
      forever #50 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         results;
      end
   end
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ***********************************
   // reference model of the factory info row
   // ***********************************
   function automatic logic [7:0] sig_exp(input int a);
      if (a <= 2) return ID_VAL[23-8*a -: 8];
      if (a == 4 || a == 5) return GAIN_VAL[8*(a-4) +: 8];
      if (a == 6 || a == 7) return OFS_VAL[8*(a-6) +: 8];
      if (a >= 16) return SER_VAL[8*(a-16) +: 8];
      return 8'h00;
   endfunction
   // one access on the programming port (p=1) or the cpu port
   task automatic acc(input bit p, input logic w, input sfa_pkg::sfa_area_e ar, input int a,
      input logic [7:0] d, input logic xrf, input logic [7:0] xrd);
      logic [7:0] rd;
      logic rf;
      logic ak;
      if (p) sfa_prog_model_inst.xfer(w, ar, a[4:0], d, rd, rf, ak);
      else cpu_drv.xfer(w, ar, a[4:0], d, rd, rf, ak);
      chk("ack", 64'h1, {63'h0, ak});
      chk("refused", {63'h0, xrf}, {63'h0, rf});
      chk("rdata", {56'h0, xrd}, {56'h0, rd});
   endtask
   // reset, then fuses copied into the targets on the first edge
   task automatic do_reset(input logic p);
      @(posedge clock);
      rst <= 1'b1;
      por <= p;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      por <= 1'b0;
      @(posedge clock);
      #1;
      tg = {fz[0], fz[1], fz[2], fz[5], fz[6], fz[7], fz[8]};
      chk("startup_done", 64'h1, {63'h0, startup_done});
      chk("targets", {8'h0, tg}, {8'h0, targets});
   endtask
   initial begin
      void'($urandom(32'hD2CD));
      fz = '{`SFA_DEF_WDT, `SFA_DEF_BOD, `SFA_DEF_OSC, 8'h00, 8'h00, `SFA_DEF_SYS_A,
         `SFA_DEF_SYS_B, `SFA_DEF_APP, `SFA_DEF_BOOT};
      for (int i = 0; i < 32; i++) ub[i] = `SFA_USER_ERASED;
      do_reset(1'b1);
      $display("test startup done");
      for (int a = 0; a < 32; a++) acc(0, 0, AR_SIG, a, 0, 0, sig_exp(a));
      acc(1, 1, AR_SIG, 0, 8'hA5, 1, 0);
      acc(0, 1, AR_SIG, 3, 8'h5A, 1, 0);
      acc(0, 0, AR_SIG, 0, 0, 0, sig_exp(0));
      acc(0, 0, AR_SIG, 3, 0, 0, 0);
      $display("test info row done");
      for (int a = 0; a < 32; a++) begin
         v = 8'($urandom);
         ub[a] = v;
         acc(0, 1, AR_USER, a, v, 0, 0);
      end
      @(posedge clock);
      locked <= 1'b1;
      v = 8'($urandom);
      ub[31] = v;
      acc(1, 1, AR_USER, 31, v, 0, 0);
      acc(1, 0, AR_USER, 31, 0, 1, 0);
      acc(1, 0, AR_SIG, 2, 0, 0, sig_exp(2));
      acc(1, 0, AR_SIG, 16, 0, 1, 0);
      acc(1, 0, AR_FUSE, 5, 0, 0, fz[5]);
      for (int a = 0; a < 32; a++) acc(0, 0, AR_USER, a, 0, 0, ub[a]);
      @(posedge clock);
      locked <= 1'b0;
      acc(1, 0, AR_USER, 31, 0, 0, ub[31]);
      $display("test user area done");
      for (int a = 0; a < 9; a++) begin
         v = 8'($urandom);
         if (a == 2) v = v & 8'h0F;
         if (a != 3 && a != 4) fz[a] = v;
         acc(1, 1, AR_FUSE, a, v, 0, 0);
      end
      acc(0, 1, AR_FUSE, 0, 8'h3C, 1, 0);
      for (int a = 0; a < 9; a++) acc(0, 0, AR_FUSE, a, 0, 0, fz[a]);
      chk("targets held", {8'h0, tg}, {8'h0, targets});
      do_reset(1'b0);
      acc(0, 0, AR_USER, 7, 0, 0, ub[7]);
      $display("test fuses done");
      results;
   end
endmodule
bind sfa_nv_access sfa_nv_asserts sfa_nv_asserts_inst (.clock(clock), .rst(rst), .por(por),
   .locked(locked), .cpu_req(cpu_req), .prg_req(prg_req), .cpu_rsp(cpu_rsp),
   .prg_rsp(prg_rsp), .targets(targets), .startup_done(startup_done));

// ---- logic/sfa_map.svh ----
// offsets, field positions and factory values of the factory info row, user area and fuses
`ifndef SFA_MAP_SVH
`define SFA_MAP_SVH
// factory info row byte offsets
`define SFA_SIG_ID_FIRST 5'h00
`define SFA_SIG_ID_LAST 5'h02
`define SFA_SIG_GAIN_LO 5'h04
`define SFA_SIG_GAIN_HI 5'h05
`define SFA_SIG_OFS_LO 5'h06
`define SFA_SIG_OFS_HI 5'h07
`define SFA_SIG_SER_FIRST 5'h10
`define SFA_SIG_SER_LAST 5'h1F
// fuse byte offsets
`define SFA_FUSE_WDT 5'h00
`define SFA_FUSE_BOD 5'h01
`define SFA_FUSE_OSC 5'h02
`define SFA_FUSE_SYS_A 5'h05
`define SFA_FUSE_SYS_B 5'h06
`define SFA_FUSE_APP 5'h07
`define SFA_FUSE_BOOT 5'h08
// watchdog fuse field positions
`define SFA_WDT_WIN_MSB 7
`define SFA_WDT_WIN_LSB 4
`define SFA_WDT_PER_MSB 3
`define SFA_WDT_PER_LSB 0
// factory-programmed fuse values and erased user byte
`define SFA_DEF_WDT 8'h00
`define SFA_DEF_BOD 8'h00
`define SFA_DEF_OSC 8'h00
`define SFA_DEF_SYS_A 8'hC0
`define SFA_DEF_SYS_B 8'h00
`define SFA_DEF_APP 8'h00
`define SFA_DEF_BOOT 8'h00
`define SFA_USER_ERASED 8'hFF
`define SFA_USER_BYTES 32
`endif

// ---- logic/sfa_nv_access.sv ----
// access logic for the factory info row, the user data area and the fuses
//
// Function
// - three read-only part identifier bytes sit at factory info row offsets 0x00 to 0x02.
// - two thermal calibration words sit at 0x04 and 0x06, gain unsigned, offset signed.
// - each calibration word is 16 bits, low byte at the lower address, high byte next.
// - sixteen read-only unique serial bytes sit at offsets 0x10 through 0x1F.
// - the 32-byte user data area keeps its contents across a chip erase.
// - the programming port may write the user data area even while the part is locked.
// - while locked the programming port may not read the user data area.
// - the cpu reads and writes the user data area like ordinary program flash.
// - both sides read fuses, only the programming port may program them.
// - at the end of start-up every fuse value is copied into its target register.
// - a newly programmed fuse only takes effect when reloaded after the next reset.
// - the watchdog fuse high nibble loads the window field, the low nibble the period.
// - the part identifier bytes stay readable on the programming port when locked.
// - no write from any port alters the factory info row.
`timescale 1ns/10ps
`include "sfa_map.svh"

module sfa_nv_access #(
   // arbitrary neutral identifier, not any real part
   parameter logic [23:0] PART_ID = 24'h5A_A5_01,
   // arbitrary calibration and serial values
   parameter logic [15:0] GAIN_CAL = 16'h1000,
   parameter logic [15:0] OFFSET_CAL = 16'h0000,
   parameter logic [127:0] SERIAL = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic por,
   input wire logic locked,
   input wire sfa_pkg::sfa_req_s cpu_req,
   input wire sfa_pkg::sfa_req_s prg_req,
   output sfa_pkg::sfa_rsp_s cpu_rsp,
   output sfa_pkg::sfa_rsp_s prg_rsp,
   output sfa_pkg::sfa_targets_s targets,
   output logic startup_done
);

   // ******************************************************
   // state
   // ******************************************************

   // control state, cleared by system reset
   typedef struct packed {
      sfa_pkg::sfa_state_e state;
      logic done;
      sfa_pkg::sfa_rsp_s cpu_rsp;
      sfa_pkg::sfa_rsp_s prg_rsp;
      sfa_pkg::sfa_targets_s targets;
   } sfa_ctl_s;

   // nonvolatile contents, untouched by system reset
   typedef struct packed {
      sfa_pkg::sfa_fuse_s fuse;
      logic [`SFA_USER_BYTES-1:0][7:0] user;
   } sfa_nv_s;

   sfa_ctl_s ctl_ff;
   sfa_ctl_s nxt_ctl;
   sfa_nv_s nv_ff;
   sfa_nv_s nxt_nv;

   // ******************************************************
   // functions
   // ******************************************************

   // factory info row byte at an offset
   function automatic logic [7:0] sig_byte(input logic [4:0] a);
      logic [7:0] b;
      b = 8'h00;
      case (a)
         `SFA_SIG_ID_FIRST: begin
            b = PART_ID[23:16];
         end
         5'h01: begin
            b = PART_ID[15:8];
         end
         `SFA_SIG_ID_LAST: begin
            b = PART_ID[7:0];
         end
         `SFA_SIG_GAIN_LO: begin
            b = GAIN_CAL[7:0];
         end
         `SFA_SIG_GAIN_HI: begin
            b = GAIN_CAL[15:8];
         end
         `SFA_SIG_OFS_LO: begin
            b = OFFSET_CAL[7:0];
         end
         `SFA_SIG_OFS_HI: begin
            b = OFFSET_CAL[15:8];
         end
         default: begin
            // serial bytes in the upper half, reserved reads zero
            if (a[4]) begin
               b = SERIAL[{a[3:0], 3'b000} +: 8];
            end else begin
               b = 8'h00;
            end
         end
      endcase
      return b;
   endfunction

   // stored fuse byte at an offset, reserved offsets read zero
   function automatic logic [7:0] fuse_byte(input sfa_pkg::sfa_fuse_s f,
                                            input logic [4:0] a);
      logic [7:0] b;
      b = 8'h00;
      case (a)
         `SFA_FUSE_WDT: begin
            b = f.wdt;
         end
         `SFA_FUSE_BOD: begin
            b = f.bod;
         end
         `SFA_FUSE_OSC: begin
            b = f.osc;
         end
         `SFA_FUSE_SYS_A: begin
            b = f.sys_a;
         end
         `SFA_FUSE_SYS_B: begin
            b = f.sys_b;
         end
         `SFA_FUSE_APP: begin
            b = f.app;
         end
         `SFA_FUSE_BOOT: begin
            b = f.boot;
         end
         default: begin
            b = 8'h00;
         end
      endcase
      return b;
   endfunction

   // read data of any area
   function automatic logic [7:0] area_read(input sfa_pkg::sfa_req_s r,
                                            input sfa_nv_s n);
      logic [7:0] b;
      b = 8'h00;
      case (r.area)
         sfa_pkg::SFA_AREA_SIG: begin
            b = sig_byte(r.addr);
         end
         sfa_pkg::SFA_AREA_USER: begin
            b = n.user[r.addr];
         end
         sfa_pkg::SFA_AREA_FUSE: begin
            b = fuse_byte(n.fuse, r.addr);
         end
         default: begin
            b = 8'h00;
         end
      endcase
      return b;
   endfunction

   // store a programmed fuse byte, reserved offsets are ignored
   function automatic sfa_pkg::sfa_fuse_s fuse_write(input sfa_pkg::sfa_fuse_s f,
                                                     input logic [4:0] a,
                                                     input logic [7:0] d);
      sfa_pkg::sfa_fuse_s g;
      g = f;
      case (a)
         `SFA_FUSE_WDT: begin
            g.wdt = d;
         end
         `SFA_FUSE_BOD: begin
            g.bod = d;
         end
         `SFA_FUSE_OSC: begin
            g.osc = d;
         end
         `SFA_FUSE_SYS_A: begin
            g.sys_a = d;
         end
         `SFA_FUSE_SYS_B: begin
            g.sys_b = d;
         end
         `SFA_FUSE_APP: begin
            g.app = d;
         end
         `SFA_FUSE_BOOT: begin
            g.boot = d;
         end
         default: begin
            g = f;
         end
      endcase
      return g;
   endfunction

   // ******************************************************
   // access checks
   // ******************************************************

   logic run;
   logic cpu_take;
   logic prg_take;
   logic cpu_refuse;
   logic prg_refuse;

   // requests are only taken once the fuses are loaded
   assign run = (ctl_ff.state == sfa_pkg::SFA_ST_RUN);
   assign cpu_take = run & cpu_req.valid;
   assign prg_take = run & prg_req.valid;

   // cpu may not touch the info row or fuses for writing
   always_comb begin
      cpu_refuse = 1'b0;
      case (cpu_req.area)
         sfa_pkg::SFA_AREA_SIG: begin
            cpu_refuse = cpu_req.write;
         end
         sfa_pkg::SFA_AREA_USER: begin
            cpu_refuse = 1'b0;
         end
         sfa_pkg::SFA_AREA_FUSE: begin
            cpu_refuse = cpu_req.write;
         end
         default: begin
            cpu_refuse = 1'b1;
         end
      endcase
   end

   // programming port rights depend on the lock
   always_comb begin
      prg_refuse = 1'b0;
      case (prg_req.area)
         sfa_pkg::SFA_AREA_SIG: begin
            if (prg_req.write) begin
               prg_refuse = 1'b1;
            end else begin
               // only the identifier bytes are open while locked
               prg_refuse = locked & (prg_req.addr > `SFA_SIG_ID_LAST);
            end
         end
         sfa_pkg::SFA_AREA_USER: begin
            // writes always allowed, reads shut while locked
            prg_refuse = locked & ~prg_req.write;
         end
         sfa_pkg::SFA_AREA_FUSE: begin
            prg_refuse = 1'b0;
         end
         default: begin
            prg_refuse = 1'b1;
         end
      endcase
   end

   // ******************************************************
   // control next state
   // ******************************************************

   always_comb begin
      nxt_ctl = ctl_ff;
      nxt_ctl.cpu_rsp = '0;
      nxt_ctl.prg_rsp = '0;
      case (ctl_ff.state)
         sfa_pkg::SFA_ST_LOAD: begin
            // copy stored fuses into their targets once per reset
            nxt_ctl.targets.wdt_window = nv_ff.fuse.wdt[`SFA_WDT_WIN_MSB:`SFA_WDT_WIN_LSB];
            nxt_ctl.targets.wdt_period = nv_ff.fuse.wdt[`SFA_WDT_PER_MSB:`SFA_WDT_PER_LSB];
            nxt_ctl.targets.bod = nv_ff.fuse.bod;
            nxt_ctl.targets.osc = nv_ff.fuse.osc;
            nxt_ctl.targets.sys_a = nv_ff.fuse.sys_a;
            nxt_ctl.targets.sys_b = nv_ff.fuse.sys_b;
            nxt_ctl.targets.app = nv_ff.fuse.app;
            nxt_ctl.targets.boot = nv_ff.fuse.boot;
            nxt_ctl.done = 1'b1;
            nxt_ctl.state = sfa_pkg::SFA_ST_RUN;
         end
         sfa_pkg::SFA_ST_RUN: begin
            // targets hold until the next reset
            nxt_ctl.targets = ctl_ff.targets;
            if (cpu_take) begin
               nxt_ctl.cpu_rsp.ack = 1'b1;
               nxt_ctl.cpu_rsp.refused = cpu_refuse;
               if (!cpu_req.write && !cpu_refuse) begin
                  nxt_ctl.cpu_rsp.rdata = area_read(cpu_req, nv_ff);
               end
            end
            if (prg_take) begin
               nxt_ctl.prg_rsp.ack = 1'b1;
               nxt_ctl.prg_rsp.refused = prg_refuse;
               if (!prg_req.write && !prg_refuse) begin
                  nxt_ctl.prg_rsp.rdata = area_read(prg_req, nv_ff);
               end
            end
         end
         default: begin
            nxt_ctl.state = sfa_pkg::SFA_ST_LOAD;
         end
      endcase
   end

   // ******************************************************
   // nonvolatile next state
   // ******************************************************

   always_comb begin
      nxt_nv = nv_ff;
      if (por) begin
         // factory values on first power-up
         nxt_nv.fuse.wdt = `SFA_DEF_WDT;
         nxt_nv.fuse.bod = `SFA_DEF_BOD;
         nxt_nv.fuse.osc = `SFA_DEF_OSC;
         nxt_nv.fuse.sys_a = `SFA_DEF_SYS_A;
         nxt_nv.fuse.sys_b = `SFA_DEF_SYS_B;
         nxt_nv.fuse.app = `SFA_DEF_APP;
         nxt_nv.fuse.boot = `SFA_DEF_BOOT;
         for (int i = 0; i < `SFA_USER_BYTES; i++) begin
            nxt_nv.user[i] = `SFA_USER_ERASED;
         end
      end else begin
         // cpu user write first, programmer wins a clash
         if (cpu_take && cpu_req.write && !cpu_refuse &&
             cpu_req.area == sfa_pkg::SFA_AREA_USER) begin
            nxt_nv.user[cpu_req.addr] = cpu_req.wdata;
         end
         if (prg_take && prg_req.write && !prg_refuse) begin
            if (prg_req.area == sfa_pkg::SFA_AREA_USER) begin
               nxt_nv.user[prg_req.addr] = prg_req.wdata;
            end else if (prg_req.area == sfa_pkg::SFA_AREA_FUSE) begin
               // stored only, takes effect at the next load
               nxt_nv.fuse = fuse_write(nv_ff.fuse, prg_req.addr, prg_req.wdata);
            end
         end
      end
   end

   // ******************************************************
   // registers
   // ******************************************************

   // control flops with asynchronous reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctl_ff.state <= sfa_pkg::SFA_ST_LOAD;
         ctl_ff.done <= 1'b0;
         ctl_ff.cpu_rsp <= '0;
         ctl_ff.prg_rsp <= '0;
         ctl_ff.targets.wdt_window <= 4'(`SFA_DEF_WDT >> `SFA_WDT_WIN_LSB);
         ctl_ff.targets.wdt_period <= 4'(`SFA_DEF_WDT >> `SFA_WDT_PER_LSB);
         ctl_ff.targets.bod <= `SFA_DEF_BOD;
         ctl_ff.targets.osc <= `SFA_DEF_OSC;
         ctl_ff.targets.sys_a <= `SFA_DEF_SYS_A;
         ctl_ff.targets.sys_b <= `SFA_DEF_SYS_B;
         ctl_ff.targets.app <= `SFA_DEF_APP;
         ctl_ff.targets.boot <= `SFA_DEF_BOOT;
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // storage flops keep their contents through system reset, no erase path
   always_ff @(posedge clock) begin
      nv_ff <= nxt_nv;
   end

   // ******************************************************
   // outputs
   // ******************************************************

   // every output is a flop
   assign cpu_rsp = ctl_ff.cpu_rsp;
   assign prg_rsp = ctl_ff.prg_rsp;
   assign targets = ctl_ff.targets;
   assign startup_done = ctl_ff.done;

endmodule

// ---- logic/sfa_pkg.sv ----
// types shared by the nonvolatile access block
package sfa_pkg;
   typedef enum logic [1:0] {
      SFA_AREA_SIG = 2'h0,
      SFA_AREA_USER = 2'h1,
      SFA_AREA_FUSE = 2'h2,
      SFA_AREA_NONE = 2'h3
   } sfa_area_e;
   typedef enum logic [1:0] {
      SFA_ST_LOAD = 2'b01,
      SFA_ST_RUN = 2'b10
   } sfa_state_e;
   typedef struct packed {
      logic valid;
      logic write;
      sfa_area_e area;
      logic [4:0] addr;
      logic [7:0] wdata;
   } sfa_req_s;
   typedef struct packed {
      logic ack;
      logic refused;
      logic [7:0] rdata;
   } sfa_rsp_s;
   typedef struct packed {
      logic [7:0] wdt;
      logic [7:0] bod;
      logic [7:0] osc;
      logic [7:0] sys_a;
      logic [7:0] sys_b;
      logic [7:0] app;
      logic [7:0] boot;
   } sfa_fuse_s;
   typedef struct packed {
      logic [3:0] wdt_window;
      logic [3:0] wdt_period;
      logic [7:0] bod;
      logic [7:0] osc;
      logic [7:0] sys_a;
      logic [7:0] sys_b;
      logic [7:0] app;
      logic [7:0] boot;
   } sfa_targets_s;
endpackage
